//--- pio_pkg.sv
/*
 Constants, register map and carrier types of the pattern I/O timing controller.
 Assumes a 40 MHz system clock and an APB master with 32-bit data.
*/
package pio_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_NS = 25;
	localparam int TB_NS_20M = 50;
	localparam int TB_NS_10M = 100;
	localparam int TB_NS_1M = 1000;
	localparam int TB_NS_100K = 10000;
	localparam int TB_NS_10K = 100000;
	localparam int TB_NS_1K = 1000000;
	localparam int TB_NS_100 = 10000000;
	localparam int GLITCH_NS = 20;
	localparam int HOLD_NS = 60;
	localparam int GLITCH_CYC = (GLITCH_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int HOLD_CYC = HOLD_NS / CLOCK_NS;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] CMD_OFF = 8'h04;
	localparam logic [7:0] DIV_OFF = 8'h08;
	localparam logic [7:0] COUNT_OFF = 8'h0c;
	localparam logic [7:0] PRE_OFF = 8'h10;
	localparam logic [7:0] POST_OFF = 8'h14;
	localparam logic [7:0] PATTERN_OFF = 8'h18;
	localparam logic [7:0] MASK_OFF = 8'h1c;
	localparam logic [7:0] STATUS_OFF = 8'h20;
	localparam logic [7:0] SAMPLES_OFF = 8'h24;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_ABORT_BIT = 1;
	localparam logic [15:0] DIV_MIN = 16'h0001;
	localparam logic [15:0] DIV_MAX = 16'hff4b;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [31:0] COUNT_RST = 32'h0000_0001;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {W8, W16, W32} width_t;
	typedef struct packed {
		logic [2:0] timebase;
		logic handshake;
		logic overwrite;
		logic continuous;
		logic matchOnMismatch;
		logic matchIsStop;
		logic matchEn;
		logic stopTrigEn;
		logic startTrigEn;
		logic strobeInvert;
		logic extStrobe;
		logic group;
		width_t width;
		logic dirIn;
	} cfg_t;
	localparam cfg_t CFG_RST = '0;
	typedef struct packed {
		logic errOverflow;
		logic errPretrig;
		logic done;
		logic armed;
		logic busy;
	} status_t;
	typedef enum logic [2:0] {IDLE, ARMED, RUN, POST, FLUSH} state_t;
endpackage

//--- pattern_io_timing_controller.sv
/*
 Pattern I/O timing controller: strobe generation, triggering and sample counting.
 Assumes an APB master on the system clock and a peripheral on asynchronous pins.
*/
`timescale 1ns/1ps
// What this block does
// [R1] Move one pattern per active strobe edge; strobe internal counter or external pin.
// [R2] Width 8, 16 or 32 bits on the lanes that the group selects; at 32 bits group 1 reads all 32 lanes but drives none.
// [R3] Each transfer is either output or input.
// [R4] Active edge programmable; default rising external, falling internal.
// [R5] Peripheral supplies its own sample clock when external strobing is chosen.
// [R6] Internal rate is timebase frequency divided by divisor.
// [R7] Divisor accepts 1 through 65355.
// [R8] Software start by default; hardware may start, stop or both.
// [R9] Group trigger lines serve as trigger inputs in pattern mode.
// [R10] Hardware triggers disabled in handshaking mode.
// [R11] Start triggering waits for an active start trigger.
// [R12] Stop trigger keeps pretrigger and posttrigger samples then halts.
// [R13] Stop before pretrigger count collected is an error.
// [R14] Start and stop combined: begin on start, end after stop.
// [R15] Stop trigger before start is ignored.
// [R16] Pattern match may start or stop input transfers, never both.
// [R17] Masked compare with pattern; polarity picks match or mismatch.
// [R18] Detect matches held 60 ns, reject glitches under 20 ns.
// [R19] Finite mode moves exactly the programmed count then ends.
// [R20] Continuous input halts with error when buffer full, unless overwriting.
// [R21] Overwriting keeps acquiring after the buffer fills.
// [R22] Finite external input needs one extra strobe edge to flush last word.
// [R23] Internal strobe pulses when tick count reaches divisor, then reloads.
module pattern_io_timing_controller
#(
	parameter int TB_CYC_1K = pio_pkg::TB_NS_1K / pio_pkg::CLOCK_NS,
	parameter int TB_CYC_100 = pio_pkg::TB_NS_100 / pio_pkg::CLOCK_NS
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] dataIn,
	output logic [31:0] dataOut,
	output logic [31:0] dataOeN,
	input wire logic strobeIn,
	output logic strobeOut,
	output logic strobeOeN,
	input wire logic [1:0] beginTriggerIn,
	input wire logic [1:0] haltTriggerIn,
	output logic [31:0] sampleWord,
	output logic sampleValid,
	input wire logic bufferFull,
	input wire logic [31:0] outWord,
	output logic outTake
);
	import pio_pkg::*;
	// ****************************************
	// Registers
	// ****************************************
	cfg_t cfg;
	status_t status;
	state_t state;
	logic [15:0] divisor;
	logic [31:0] countReg, preReg, postReg, pattern, mask, samples, postLeft;
	logic startCmd, abortCmd;
	logic [31:0] next_prdata;
	logic mapped;
	always_comb
	begin
		mapped = 1'b1;
		next_prdata = WORD_RST;
		case (paddr)
			CTRL_OFF: next_prdata = {15'h0000, cfg};
			CMD_OFF: next_prdata = WORD_RST;
			DIV_OFF: next_prdata = {16'h0000, divisor};
			COUNT_OFF: next_prdata = countReg;
			PRE_OFF: next_prdata = preReg;
			POST_OFF: next_prdata = postReg;
			PATTERN_OFF: next_prdata = pattern;
			MASK_OFF: next_prdata = mask;
			STATUS_OFF: next_prdata = {27'h0000000, status};
			SAMPLES_OFF: next_prdata = samples;
			default: mapped = 1'b0;
		endcase
	end
	wire logic wrEn = psel & penable & pready & pwrite & ~pslverr;
	// The answer comes in the first access cycle; reads are latched at setup.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= WORD_RST;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable) ? next_prdata : prdata;
		end
	end
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg <= CFG_RST;
			divisor <= DIV_RST;
			countReg <= COUNT_RST;
			preReg <= WORD_RST;
			postReg <= WORD_RST;
			pattern <= WORD_RST;
			mask <= WORD_RST;
			startCmd <= 1'b0;
			abortCmd <= 1'b0;
		end
		else
		begin
			startCmd <= wrEn && paddr == CMD_OFF && pwdata[CMD_START_BIT];
			abortCmd <= wrEn && paddr == CMD_OFF && pwdata[CMD_ABORT_BIT];
			if (wrEn && paddr == CTRL_OFF)
				cfg <= cfg_t'(pwdata[16:0]);
			// [R7] Divisor range clamp
			if (wrEn && paddr == DIV_OFF)
				divisor <= pwdata[15:0] < DIV_MIN ? DIV_MIN : (pwdata[15:0] > DIV_MAX ? DIV_MAX : pwdata[15:0]);
			if (wrEn && paddr == COUNT_OFF)
				countReg <= pwdata;
			if (wrEn && paddr == PRE_OFF)
				preReg <= pwdata;
			if (wrEn && paddr == POST_OFF)
				postReg <= pwdata;
			if (wrEn && paddr == PATTERN_OFF)
				pattern <= pwdata;
			if (wrEn && paddr == MASK_OFF)
				mask <= pwdata;
		end
	end
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [36:0] syncA, syncB;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			syncA <= '0;
			syncB <= '0;
		end
		else
		begin
			syncA <= {strobeIn, beginTriggerIn, haltTriggerIn, dataIn};
			syncB <= syncA;
		end
	end
	wire logic [31:0] dataSync = syncB[31:0];
	// [R9] Group trigger lines
	wire logic haltLine = syncB[32 + 32'(cfg.group)];
	wire logic beginLine = syncB[34 + 32'(cfg.group)];
	logic haltLast, beginLast, strobeLast;
	// ****************************************
	// Internal strobe
	// ****************************************
	logic [18:0] tbCnt, tbLimit;
	logic [15:0] divCnt;
	logic intStrobe;
	always_comb
	begin
		case (cfg.timebase)
			3'h0: tbLimit = 19'(TB_NS_20M / CLOCK_NS - 1);
			3'h1: tbLimit = 19'(TB_NS_10M / CLOCK_NS - 1);
			3'h2: tbLimit = 19'(TB_NS_1M / CLOCK_NS - 1);
			3'h3: tbLimit = 19'(TB_NS_100K / CLOCK_NS - 1);
			3'h4: tbLimit = 19'(TB_NS_10K / CLOCK_NS - 1);
			3'h5: tbLimit = 19'(TB_CYC_1K - 1);
			default: tbLimit = 19'(TB_CYC_100 - 1);
		endcase
	end
	wire logic tbTick = tbCnt == tbLimit;
	wire logic running = state != IDLE;
	// [R6] Timebase over divisor
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			tbCnt <= '0;
			divCnt <= '0;
			intStrobe <= 1'b0;
		end
		else if (!running || cfg.extStrobe)
		begin
			tbCnt <= '0;
			divCnt <= '0;
			intStrobe <= 1'b0;
		end
		else
		begin
			tbCnt <= tbTick ? '0 : tbCnt + 19'h00001;
			// [R23] Reload at divisor
			if (tbTick && divCnt == divisor - 16'h0001)
			begin
				divCnt <= '0;
				intStrobe <= 1'b1;
			end
			else
			begin
				divCnt <= tbTick ? divCnt + 16'h0001 : divCnt;
				intStrobe <= 1'b0;
			end
		end
	end
	// [R5] Pin is input when the peripheral clocks
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			strobeOut <= 1'b0;
			strobeOeN <= 1'b1;
		end
		else
		begin
			strobeOut <= intStrobe;
			strobeOeN <= cfg.extStrobe;
		end
	end
	// [R4] Edge choice
	wire logic strobeLevel = cfg.extStrobe ? syncB[36] : intStrobe;
	wire logic activeRising = cfg.extStrobe ^ cfg.strobeInvert;
	wire logic strobeEdge = activeRising ? (strobeLevel & ~strobeLast) : (~strobeLevel & strobeLast);
	// ****************************************
	// Pattern match and triggers
	// ****************************************
	logic [1:0] matchRun;
	logic matchFire;
	// [R17] Masked compare with polarity
	wire logic matchRaw = (((dataSync ^ pattern) & mask) == '0) ^ cfg.matchOnMismatch;
	// [R18] One-sample glitches are filtered; a 60 ns level spans two samples.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			matchRun <= '0;
			matchFire <= 1'b0;
		end
		else
		begin
			matchRun <= !matchRaw ? '0 : (matchRun > 2'(GLITCH_CYC) ? matchRun : matchRun + 2'h1);
			matchFire <= matchRaw && matchRun == 2'(HOLD_CYC - 1);
		end
	end
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			haltLast <= 1'b0;
			beginLast <= 1'b0;
			strobeLast <= 1'b0;
		end
		else
		begin
			haltLast <= haltLine;
			beginLast <= beginLine;
			strobeLast <= strobeLevel;
		end
	end
	// [R10] Triggers only in pattern mode
	wire logic trigOk = ~cfg.handshake;
	// [R16] Match serves one role, input only
	wire logic matchOk = cfg.matchEn & cfg.dirIn & trigOk;
	wire logic startEv = matchOk & ~cfg.matchIsStop ? matchFire : beginLine & ~beginLast;
	wire logic stopEv = matchOk & cfg.matchIsStop ? matchFire : haltLine & ~haltLast;
	wire logic useStart = trigOk & (cfg.startTrigEn | (matchOk & ~cfg.matchIsStop));
	wire logic useStop = trigOk & (cfg.stopTrigEn | (matchOk & cfg.matchIsStop));
	// ****************************************
	// Lanes
	// ****************************************
	logic [31:0] laneIn, laneOut, laneEn;
	// [R2] Lane selection
	always_comb
	begin
		case (cfg.width)
			W8:
			begin
				laneIn = {24'h000000, cfg.group ? dataSync[23:16] : dataSync[7:0]};
				laneOut = cfg.group ? {8'h00, outWord[7:0], 16'h0000} : {24'h000000, outWord[7:0]};
				laneEn = cfg.group ? 32'h00ff_0000 : 32'h0000_00ff;
			end
			W16:
			begin
				laneIn = {16'h0000, cfg.group ? dataSync[31:16] : dataSync[15:0]};
				laneOut = cfg.group ? {outWord[15:0], 16'h0000} : {16'h0000, outWord[15:0]};
				laneEn = cfg.group ? 32'hffff_0000 : 32'h0000_ffff;
			end
			default:
			begin
				laneIn = dataSync;
				laneOut = outWord;
				laneEn = cfg.group ? 32'h0000_0000 : 32'hffff_ffff;
			end
		endcase
	end
	// ****************************************
	// Transfer sequencer
	// ****************************************
	wire logic moving = (state == RUN || state == POST) && strobeEdge;
	wire logic lastFinite = !cfg.continuous && !useStop && samples + 32'h1 >= countReg;
	wire logic overflow = cfg.dirIn && cfg.continuous && bufferFull && !cfg.overwrite;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= IDLE;
			status <= '0;
			samples <= '0;
			postLeft <= '0;
			sampleWord <= WORD_RST;
			sampleValid <= 1'b0;
			outTake <= 1'b0;
			dataOut <= WORD_RST;
			dataOeN <= 32'hffff_ffff;
		end
		else
		begin
			sampleValid <= 1'b0;
			outTake <= 1'b0;
			// [R3] Drive lanes only for output
			dataOeN <= (running && !cfg.dirIn) ? ~laneEn : 32'hffff_ffff;
			status.busy <= state != IDLE;
			status.armed <= state == ARMED;
			if (abortCmd)
				state <= IDLE;
			else
			case (state)
				IDLE:
					// [R8] Software start
					if (startCmd)
					begin
						status <= '0;
						samples <= '0;
						state <= useStart ? ARMED : RUN;
					end
				// [R11] Wait for start trigger
				// [R15] Stop ignored before start
				ARMED:
					if (startEv)
						state <= RUN;
				RUN, POST:
				begin
					// [R1] One pattern per edge
					if (moving)
					begin
						samples <= samples + 32'h1;
						sampleWord <= laneIn;
						sampleValid <= cfg.dirIn;
						outTake <= !cfg.dirIn;
						dataOut <= laneOut;
						if (state == POST)
							postLeft <= postLeft - 32'h1;
					end
					// [R20] Full buffer stops with error
					// [R21] Overwrite keeps running
					if (moving && overflow)
					begin
						status.errOverflow <= 1'b1;
						state <= IDLE;
					end
					// [R12] Stop trigger then posttrigger
					// [R14] Combined start and stop
					else if (state == RUN && useStop && stopEv)
					begin
						// [R13] Too few pretrigger samples
						if (samples < preReg)
						begin
							status.errPretrig <= 1'b1;
							state <= IDLE;
						end
						else if (postReg == '0)
						begin
							status.done <= 1'b1;
							state <= IDLE;
						end
						else
						begin
							postLeft <= postReg;
							state <= POST;
						end
					end
					else if (state == POST && moving && postLeft == 32'h1)
					begin
						status.done <= 1'b1;
						state <= IDLE;
					end
					// [R19] Finite count
					else if (state == RUN && moving && lastFinite)
					begin
						status.done <= cfg.dirIn && cfg.extStrobe ? 1'b0 : 1'b1;
						state <= cfg.dirIn && cfg.extStrobe ? FLUSH : IDLE;
					end
				end
				// [R22] Extra edge moves last word out
				FLUSH:
					if (strobeEdge)
					begin
						status.done <= 1'b1;
						state <= IDLE;
					end
				default: state <= IDLE;
			endcase
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	property p_finite_count;
		@(posedge clock) disable iff (!nrst)
		(state == RUN && moving && lastFinite && !overflow && !(useStop && stopEv) && !abortCmd)
			|=> (samples == countReg || state == FLUSH);
	endproperty
	a_finite_count: assert property (p_finite_count) else $error("finite count missed"); // [R19]
	property p_pretrig_err;
		@(posedge clock) disable iff (!nrst)
		(state == RUN && useStop && stopEv && !moving && samples < preReg && !abortCmd) |=> status.errPretrig && state == IDLE;
	endproperty
	a_pretrig_err: assert property (p_pretrig_err) else $error("early stop not flagged"); // [R13]
	property p_armed_waits;
		@(posedge clock) disable iff (!nrst)
		(state == ARMED && !startEv && !abortCmd) |=> state == ARMED;
	endproperty
	a_armed_waits: assert property (p_armed_waits) else $error("left armed without start"); // [R11]
	property p_no_sample_armed;
		@(posedge clock) disable iff (!nrst)
		state == ARMED |=> !sampleValid && !outTake;
	endproperty
	a_no_sample_armed: assert property (p_no_sample_armed) else $error("sample before start"); // [R15]
	property p_div_range;
		@(posedge clock) disable iff (!nrst)
		divisor >= DIV_MIN && divisor <= DIV_MAX;
	endproperty
	a_div_range: assert property (p_div_range) else $error("divisor out of range"); // [R7]
	property p_overflow;
		@(posedge clock) disable iff (!nrst)
		(moving && overflow && !abortCmd) |=> status.errOverflow && state == IDLE;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not halted"); // [R20]
	property p_overwrite;
		@(posedge clock) disable iff (!nrst)
		(state == RUN && moving && cfg.overwrite && cfg.continuous && !(useStop && stopEv) && !abortCmd)
			|=> state == RUN;
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite stopped"); // [R21]
	property p_glitch;
		@(posedge clock) disable iff (!nrst)
		(!matchRaw ##1 matchRaw ##1 !matchRaw) |-> !matchFire ##1 !matchFire;
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch fired match"); // [R18]
	property p_input_float;
		@(posedge clock) disable iff (!nrst)
		cfg.dirIn && $past(cfg.dirIn) |=> dataOeN == 32'hffff_ffff;
	endproperty
	a_input_float: assert property (p_input_float) else $error("driving in input mode"); // [R3]
endmodule

//--- peripheral_model.sv
/*
 Behavioural peripheral on the far side of the pattern lines: sample clock and data.
 Assumes the bench frames the strobe with run and sets the word it presents.
*/
`timescale 1ns/1ps
module peripheral_model
(
	input wire logic run,
	input wire logic [31:0] word,
	input wire logic [31:0] dataOut,
	input wire logic [31:0] dataOeN,
	output logic strobeIn,
	output logic [31:0] dataIn
);
	// own sample clock, extra edge
	// The strobe stands low outside a frame and keeps running after the last sample.
	initial
	begin
		strobeIn = 1'b0;
		forever
		begin
			// Edges sit off the clock edges, so the pin is never sampled while it moves.
			wait (run);
			#90 strobeIn = 1'b1;
			#100 strobeIn = 1'b0;
			#10;
		end
	end
	always_comb
		for (int i = 0; i < 32; i++)
			dataIn[i] = dataOeN[i] ? word[i] : dataOut[i];
endmodule

//--- testbench.sv
/*
 Self-checking bench of the pattern I/O timing controller over APB.
 Assumes the short timebase parameters and a peripheral model on the pattern lines.
*/
`timescale 1ns/1ps
module testbench;
	import pio_pkg::*;
	logic clock, nrst, psel, penable, pwrite, pready, pslverr, strobeIn, strobeOut, strobeOeN;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, dataIn, dataOut, dataOeN, sampleWord, outWord, word, rdata;
	logic [1:0] beginTriggerIn, haltTriggerIn;
	logic sampleValid, bufferFull, outTake, run, lastErr;
	int mismatches, checkCount, validCnt, cyc, strobeCnt;

	pattern_io_timing_controller #(.TB_CYC_1K(20), .TB_CYC_100(40)) dut (.clock(clock), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
		.strobeIn(strobeIn), .strobeOut(strobeOut), .strobeOeN(strobeOeN), .beginTriggerIn(beginTriggerIn),
		.haltTriggerIn(haltTriggerIn), .sampleWord(sampleWord), .sampleValid(sampleValid),
		.bufferFull(bufferFull), .outWord(outWord), .outTake(outTake));
	peripheral_model peer (.run(run), .word(word), .dataOut(dataOut), .dataOeN(dataOeN),
		.strobeIn(strobeIn), .dataIn(dataIn));

	initial
	begin
		clock = 1'b0;
		forever
			#12.5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (sampleValid === 1'b1)
			validCnt <= validCnt + 1;
		if (strobeOut === 1'b1)
			strobeCnt <= strobeCnt + 1;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// The request is held until pready is sampled high; only the watchdog ends a wait that never sees it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rdata = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic start(input logic [31:0] ctrl, input logic [31:0] cnt);
		apb(1'b1, CMD_OFF, 32'h2);
		apb(1'b1, CTRL_OFF, ctrl);
		apb(1'b1, COUNT_OFF, cnt);
		apb(1'b1, CMD_OFF, 32'h1);
	endtask

	task automatic waitStatus(input int bitNo);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, STATUS_OFF, 32'h0);
			n++;
		end
		while (rdata[bitNo] !== 1'b1 && n < 400);
		if (rdata[bitNo] !== 1'b1)
			mismatches++;
	endtask

	task automatic waitPulse(input logic take);
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while ((take ? outTake : sampleValid) !== 1'b1 && n < 2000);
		if ((take ? outTake : sampleValid) !== 1'b1)
			mismatches++;
	endtask

	task automatic pulse(input logic h);
		@(posedge clock);
		if (h)
			haltTriggerIn <= 2'b01;
		else
			beginTriggerIn <= 2'b01;
		repeat (4) @(posedge clock);
		haltTriggerIn <= 2'b00;
		beginTriggerIn <= 2'b00;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic testRegs;
		chk("reset enables", dataOeN, 32'hffffffff);
		chk("reset strobe enable", {31'h0, strobeOeN}, 32'h1);
		apb(1'b0, CTRL_OFF, 32'h0);
		chk("ctrl reset", rdata, 32'h0);
		apb(1'b0, COUNT_OFF, 32'h0);
		chk("count reset", rdata, 32'h1);
		apb(1'b1, DIV_OFF, 32'h0);
		apb(1'b0, DIV_OFF, 32'h0);
		chk("div low", rdata, 32'h1);
		apb(1'b1, DIV_OFF, 32'hffff);
		apb(1'b0, DIV_OFF, 32'h0);
		chk("div high", rdata, 32'hff4b);
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped", {31'h0, lastErr}, 32'h1);
	endtask

	task automatic testWidths;
		logic [31:0] ctl [4] = '{32'h11, 32'h19, 32'h1b, 32'h35};
		logic [31:0] exp [4] = '{32'ha5, 32'hc3, 32'h12c3, 32'h12c344a5};
		int v;
		word <= 32'h12c344a5;
		for (int i = 0; i < 4; i++)
		begin
			start(ctl[i], 32'h3);
			v = validCnt;
			run <= 1'b1;
			waitStatus(2);
			run <= 1'b0;
			repeat (20) @(posedge clock);
			chk("lanes", sampleWord, exp[i]);
			chk("finite count", 32'(validCnt - v), 32'h3);
			chk("lines released", dataOeN, 32'hffffffff);
			apb(1'b0, SAMPLES_OFF, 32'h0);
			chk("samples", rdata, 32'h3);
		end
	endtask

	task automatic testOutput;
		int t0, s;
		outWord <= 32'h3c5a0ff1;
		apb(1'b1, DIV_OFF, 32'h2);
		start(32'h14004, 32'h2);
		s = strobeCnt;
		waitPulse(1'b1);
		t0 = cyc;
		waitPulse(1'b1);
		chk("strobe period", 32'(cyc - t0), 32'd40);
		chk("drive", dataOut, 32'h3c5a0ff1);
		chk("enables", dataOeN, 32'h0);
		chk("strobe drive", {31'h0, strobeOeN}, 32'h0);
		waitStatus(2);
		chk("strobe pulses", 32'(strobeCnt - s), 32'h2);
		apb(1'b0, SAMPLES_OFF, 32'h0);
		chk("output count", rdata, 32'h2);
	endtask

	task automatic testStart;
		int v;
		for (int hs = 1; hs >= 0; hs--)
		begin
			start(32'h51 | (hs << 13), 32'h2);
			v = validCnt;
			run <= 1'b1;
			repeat (40) @(posedge clock);
			chk("before trigger", 32'(validCnt - v), hs ? 32'h2 : 32'h0);
			pulse(1'b0);
			repeat (40) @(posedge clock);
			apb(1'b0, STATUS_OFF, 32'h0);
			if (hs)
				chk("handshake software start", {30'h0, rdata[2:1]}, 32'h2);
			else
			begin
				waitStatus(2);
				chk("triggered count", 32'(validCnt - v), 32'h2);
			end
			run <= 1'b0;
		end
	endtask

	task automatic testStop;
		int v;
		apb(1'b1, PRE_OFF, 32'h4);
		apb(1'b1, POST_OFF, 32'h0);
		start(32'h91, 32'h1);
		run <= 1'b1;
		pulse(1'b1);
		repeat (20) @(posedge clock);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk("early stop", {31'h0, rdata[3]}, 32'h1);
		apb(1'b1, PRE_OFF, 32'h1);
		apb(1'b1, POST_OFF, 32'h2);
		start(32'h91, 32'h1);
		repeat (3) waitPulse(1'b0);
		v = validCnt + 1;
		pulse(1'b1);
		waitStatus(2);
		chk("posttrigger", 32'(validCnt - v), 32'h2);
		chk("no error", rdata & 32'h18, 32'h0);
		start(32'hd1, 32'h1);
		pulse(1'b1);
		repeat (40) @(posedge clock);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk("stop before start", {30'h0, rdata[2:1]}, 32'h1);
		pulse(1'b0);
		repeat (3) waitPulse(1'b0);
		v = validCnt + 1;
		pulse(1'b1);
		waitStatus(2);
		chk("combined post", 32'(validCnt - v), 32'h2);
		run <= 1'b0;
	endtask

	task automatic testOverflow;
		for (int ow = 0; ow < 2; ow++)
		begin
			bufferFull <= 1'b1;
			start(32'h811 | (ow << 12), 32'h1);
			run <= 1'b1;
			repeat (60) @(posedge clock);
			apb(1'b0, STATUS_OFF, 32'h0);
			chk("overflow", rdata & 32'h11, ow ? 32'h1 : 32'h10);
		end
		bufferFull <= 1'b0;
		run <= 1'b0;
	endtask

	task automatic testMatch;
		logic [31:0] idle [2] = '{32'h0, 32'h123456a5};
		logic [31:0] fire [2] = '{32'hff0000a5, 32'h0};
		int v;
		apb(1'b1, PATTERN_OFF, 32'ha5);
		apb(1'b1, MASK_OFF, 32'hff);
		for (int pol = 0; pol < 2; pol++)
		begin
			word <= idle[pol];
			start(32'h151 | (pol << 10), 32'h2);
			v = validCnt;
			run <= 1'b1;
			repeat (40) @(posedge clock);
			chk("no match", 32'(validCnt - v), 32'h0);
			word <= fire[pol];
			waitStatus(2);
			chk("match start", 32'(validCnt - v), 32'h2);
			run <= 1'b0;
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#2000000;
		mismatches++;
		conclude;
	end

	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		beginTriggerIn = 2'b00;
		haltTriggerIn = 2'b00;
		bufferFull = 1'b0;
		outWord = 32'h0;
		word = 32'h0;
		run = 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		testRegs;
		testWidths;
		testOutput;
		testStart;
		testStop;
		testOverflow;
		testMatch;
		conclude;
	end
endmodule
